// ==== hw/rf_event_timer_rx_wait.sv ====
// event-driven down-counting second timer plus receive wait guard timer
// assumes transceiver event inputs are one-cycle pulses on ref_clk_in,
// own field level comes from logic on ref_clk_in, external field from a pin
//
// Contract
// R1: external field lost stop enable halts the timer when external field vanishes
// R2: own field on stop enable halts the timer when own field switches on
// R3: own field off stop enable halts the timer when own field switches off
// R4: receive begin start enable launches the timer at first received bit
// R5: receive end start enable launches the timer when reception completes
// R6: transmit begin start enable launches the timer when transmission starts
// R7: transmit end start enable launches the timer when transmission finishes
// R8: external field seen start enable launches the timer on field detection
// R9: external field lost start enable launches the timer when field disappears
// R10: own field on start enable launches the timer when own field turns on
// R11: own field off start enable launches the timer when own field turns off
// R12: immediate start bit launches the timer without waiting for any event
// R13: three-bit selector picks 6.78 MHz down to 53 kHz tick rate
// R14: mode bit 0 ticks at 13.56 MHz, 1 ticks at the prescaled rate
// R15: reload disabled: timer stops at expiry and holds zero
// R16: reload enabled: timer reloads preset at expiry and keeps counting
// R17: guard reload in bits 8 to 27, zero disables the guard time
// R18: guard prescaler reload in bits 0 to 7
// R19: software programs guard prescaler to 0x7f for power control and type a
// R20: receive begin stop enable halts the timer after first four bits
// R21: transmit begin stop enable halts the timer when transmission starts
// R22: external field seen stop enable halts the timer on field detection
// R23: start loads preset, counts down per tick until zero or stop
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns

module rf_event_timer_rx_wait (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// transceiver and field events
	input wire logic receive_begin_in,
	input wire logic receive_nibble_done_in,
	input wire logic receive_end_in,
	input wire logic transmit_begin_in,
	input wire logic transmit_end_in,
	input wire logic external_field_present_in,
	input wire logic own_field_on_in,
	// block outputs
	output logic timer_running_out,
	output logic timer_expired_out,
	output logic rx_guard_active_out
);
	import rf_timer_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b01,
		TMR_RUN = 2'b10
	} tmr_state_e;

	typedef struct packed {
		logic ext_sync1;
		logic ext_sync2;
		logic ext_prev;
		logic own_prev;
		logic [31:0] phase;
		logic [7:0] psc_cnt;
		logic [31:0] tmr_cfg;
		logic [31:0] rxw_cfg;
		logic [31:0] preset;
		logic [31:0] count;
		tmr_state_e tstate;
		logic expired_flag;
		logic expire_pulse;
		logic [7:0] rxw_psc;
		logic [19:0] rxw_cnt;
		logic rxw_active;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;

	state_s cur_reg;
	state_s cur_next;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// merge byte lanes of a write, only writable bits change
	function automatic logic [31:0] merge_write(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb,
		input logic [31:0] mask
	);
		logic [31:0] lane;
		lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old_val & ~lane) | (new_val & lane);
	endfunction : merge_write

	// index of a word address, an unaligned address maps nowhere
	function automatic logic [7:0] word_index(input logic [7:0] byte_addr);
		return (byte_addr[1:0] == 2'b00) ? {2'b00, byte_addr[7:2]} : 8'hff;
	endfunction : word_index

	// ----------------------------------------------------------------
	// combinational signals
	// ----------------------------------------------------------------
	logic [32:0] phase_sum;
	logic unit_tick, psc_tick, timer_tick;
	logic [8:0] psc_mask_wide;
	logic [7:0] psc_mask;
	logic ext_seen, ext_lost, own_on, own_off;
	logic write_fire;
	logic [7:0] write_index;
	logic start_now_write, expired_clear;
	logic start_hit, stop_hit;
	logic [2:0] rate_sel;
	logic [19:0] rxw_value;
	logic [7:0] rxw_psc_reload;
	logic [7:0] read_index;
	logic [31:0] read_data;
	logic read_hit;

	// contactless clock pace and prescaler tick
	always_comb begin
		phase_sum = {1'b0, cur_reg.phase} + {1'b0, UNIT_CLK_STEP};
		// carry out of the accumulator: a 13.56 MHz average rate from 50 MHz
		unit_tick = phase_sum[32];
		rate_sel = cur_reg.tmr_cfg[TICK_RATE_SELECT_MSB:TICK_RATE_SELECT_LSB];
		// divide by 2 for code 0 up to divide by 256 for code 7
		psc_mask_wide = (9'h002 << rate_sel) - 9'h001; // R13
		psc_mask = psc_mask_wide[7:0];
		psc_tick = unit_tick && ((cur_reg.psc_cnt & psc_mask) == psc_mask); // R13
		if (cur_reg.tmr_cfg[PRESCALER_USE_SELECT_BIT]) begin
			timer_tick = psc_tick; // R14
		end else begin
			timer_tick = unit_tick; // R14
		end
	end

	// field edges: external field already passed the synchroniser
	always_comb begin
		ext_seen = cur_reg.ext_sync2 && !cur_reg.ext_prev;
		ext_lost = !cur_reg.ext_sync2 && cur_reg.ext_prev;
		own_on = own_field_on_in && !cur_reg.own_prev;
		own_off = !own_field_on_in && cur_reg.own_prev;
	end

	// register write decode
	always_comb begin
		write_fire = cur_reg.aw_have && cur_reg.w_have && !cur_reg.bvalid;
		write_index = word_index(cur_reg.aw_addr);
		start_now_write = write_fire && (write_index == TIMER_CFG_INDEX)
			&& cur_reg.w_strb[0] && cur_reg.w_data[START_IMMEDIATELY_BIT]; // R12
		expired_clear = write_fire && (write_index == TIMER_STATUS_INDEX)
			&& cur_reg.w_strb[0] && cur_reg.w_data[STATUS_EXPIRED_BIT];
	end

	// launch and halt triggers
	always_comb begin
		start_hit = (cur_reg.tmr_cfg[START_ON_RECEIVE_BEGIN_BIT] && receive_begin_in) // R4
			|| (cur_reg.tmr_cfg[START_ON_RECEIVE_END_BIT] && receive_end_in) // R5
			|| (cur_reg.tmr_cfg[START_ON_TRANSMIT_BEGIN_BIT] && transmit_begin_in) // R6
			|| (cur_reg.tmr_cfg[START_ON_TRANSMIT_END_BIT] && transmit_end_in) // R7
			|| (cur_reg.tmr_cfg[START_ON_EXTERNAL_FIELD_SEEN_BIT] && ext_seen) // R8
			|| (cur_reg.tmr_cfg[START_ON_EXTERNAL_FIELD_LOST_BIT] && ext_lost) // R9
			|| (cur_reg.tmr_cfg[START_ON_OWN_FIELD_ON_BIT] && own_on) // R10
			|| (cur_reg.tmr_cfg[START_ON_OWN_FIELD_OFF_BIT] && own_off) // R11
			|| start_now_write; // R12
		stop_hit = (cur_reg.tmr_cfg[STOP_ON_RECEIVE_BEGIN_BIT] && receive_nibble_done_in) // R20
			|| (cur_reg.tmr_cfg[STOP_ON_TRANSMIT_BEGIN_BIT] && transmit_begin_in) // R21
			|| (cur_reg.tmr_cfg[STOP_ON_EXTERNAL_FIELD_SEEN_BIT] && ext_seen) // R22
			|| (cur_reg.tmr_cfg[STOP_ON_EXTERNAL_FIELD_LOST_BIT] && ext_lost) // R1
			|| (cur_reg.tmr_cfg[STOP_ON_OWN_FIELD_ON_BIT] && own_on) // R2
			|| (cur_reg.tmr_cfg[STOP_ON_OWN_FIELD_OFF_BIT] && own_off); // R3
	end

	// guard fields; software must keep the prescaler at 0x7f where needed
	always_comb begin
		rxw_value = cur_reg.rxw_cfg[RX_WAIT_VALUE_MSB:RX_WAIT_VALUE_LSB]; // R17
		rxw_psc_reload = cur_reg.rxw_cfg[RX_WAIT_PRESCALER_MSB:RX_WAIT_PRESCALER_LSB]; // R18 R19
	end

	// read mux
	always_comb begin
		read_index = word_index(s_axi_araddr_in);
		read_hit = 1'b1;
		read_data = 32'h00000000;
		if (s_axi_araddr_in[1:0] != 2'b00) begin
			read_hit = 1'b0;
		end else if (read_index == TIMER_CFG_INDEX) begin
			read_data = cur_reg.tmr_cfg;
		end else if (read_index == RX_WAIT_CFG_INDEX) begin
			read_data = cur_reg.rxw_cfg;
		end else if (read_index == TIMER_PRESET_INDEX) begin
			read_data = cur_reg.preset;
		end else if (read_index == TIMER_STATUS_INDEX) begin
			read_data[STATUS_RUNNING_BIT] = (cur_reg.tstate == TMR_RUN);
			read_data[STATUS_EXPIRED_BIT] = cur_reg.expired_flag;
			read_data[STATUS_RX_GUARD_BIT] = cur_reg.rxw_active;
		end else if (read_index == TIMER_COUNT_INDEX) begin
			read_data = cur_reg.count;
		end else begin
			read_hit = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		cur_next = cur_reg;
		cur_next.expire_pulse = 1'b0;

		// external field pin: two flops before anything reads it
		cur_next.ext_sync1 = external_field_present_in;
		cur_next.ext_sync2 = cur_reg.ext_sync1;
		cur_next.ext_prev = cur_reg.ext_sync2;
		cur_next.own_prev = own_field_on_in;

		// tick generation
		cur_next.phase = phase_sum[31:0];
		if (unit_tick) begin
			cur_next.psc_cnt = cur_reg.psc_cnt + 8'h01;
		end

		// axi write address and data are taken in either order
		if (s_axi_awvalid_in && cur_reg.awready) begin
			cur_next.aw_have = 1'b1;
			cur_next.aw_addr = s_axi_awaddr_in;
			cur_next.awready = 1'b0;
		end
		if (s_axi_wvalid_in && cur_reg.wready) begin
			cur_next.w_have = 1'b1;
			cur_next.w_data = s_axi_wdata_in;
			cur_next.w_strb = s_axi_wstrb_in;
			cur_next.wready = 1'b0;
		end
		if (write_fire) begin
			cur_next.aw_have = 1'b0;
			cur_next.w_have = 1'b0;
			cur_next.bvalid = 1'b1;
			cur_next.bresp = RESP_OKAY;
			if (cur_reg.aw_addr[1:0] != 2'b00) begin
				cur_next.bresp = RESP_SLVERR;
			end else if (write_index == TIMER_CFG_INDEX) begin
				cur_next.tmr_cfg = merge_write(cur_reg.tmr_cfg, cur_reg.w_data,
					cur_reg.w_strb, TIMER_CFG_WRITE_MASK);
			end else if (write_index == RX_WAIT_CFG_INDEX) begin
				cur_next.rxw_cfg = merge_write(cur_reg.rxw_cfg, cur_reg.w_data,
					cur_reg.w_strb, RX_WAIT_CFG_WRITE_MASK);
			end else if (write_index == TIMER_PRESET_INDEX) begin
				cur_next.preset = merge_write(cur_reg.preset, cur_reg.w_data,
					cur_reg.w_strb, 32'hffffffff);
			end else if (write_index == TIMER_STATUS_INDEX) begin
				// write one to clear the expiry flag, handled below
			end else if (write_index == TIMER_COUNT_INDEX) begin
				// count is read-only, the write is ignored
			end else begin
				cur_next.bresp = RESP_SLVERR;
			end
		end
		if (cur_reg.bvalid && s_axi_bready_in) begin
			cur_next.bvalid = 1'b0;
			cur_next.awready = 1'b1;
			cur_next.wready = 1'b1;
		end

		// axi read: one outstanding, data registered one cycle after address
		if (s_axi_arvalid_in && cur_reg.arready) begin
			cur_next.arready = 1'b0;
			cur_next.rvalid = 1'b1;
			cur_next.rdata = read_data;
			cur_next.rresp = read_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (cur_reg.rvalid && s_axi_rready_in) begin
			cur_next.rvalid = 1'b0;
			cur_next.arready = 1'b1;
		end

		// second timer: a halt in the same cycle as a launch wins,
		// so a misconfigured pair of events leaves the timer idle
		unique case (cur_reg.tstate)
			TMR_IDLE: begin
				if (start_hit && !stop_hit) begin
					cur_next.tstate = TMR_RUN; // R23
					cur_next.count = cur_reg.preset; // R23
				end
			end
			TMR_RUN: begin
				if (stop_hit) begin
					cur_next.tstate = TMR_IDLE; // R1 R2 R3 R20 R21 R22
				end else if (start_hit) begin
					cur_next.count = cur_reg.preset; // R23
				end else if (timer_tick) begin
					if (cur_reg.count > 32'h00000001) begin
						cur_next.count = cur_reg.count - 32'h00000001; // R23
					end else begin
						cur_next.expire_pulse = 1'b1;
						if (cur_reg.tmr_cfg[AUTO_RELOAD_ENABLE_BIT]) begin
							cur_next.count = cur_reg.preset; // R16
						end else begin
							cur_next.count = 32'h00000000; // R15
							cur_next.tstate = TMR_IDLE; // R15
						end
					end
				end
			end
		endcase

		// sticky expiry flag: a new expiry beats a clear in the same cycle
		cur_next.expired_flag = (cur_reg.expired_flag && !expired_clear)
			|| cur_next.expire_pulse;

		// receive wait guard: armed at transmit end, counts on contactless ticks
		if (transmit_end_in && (rxw_value != 20'h00000)) begin
			cur_next.rxw_active = 1'b1; // R17
			cur_next.rxw_cnt = rxw_value; // R17
			cur_next.rxw_psc = rxw_psc_reload; // R18
		end else if (rxw_value == 20'h00000) begin
			cur_next.rxw_active = 1'b0; // R17
		end else if (cur_reg.rxw_active && unit_tick) begin
			if (cur_reg.rxw_psc != 8'h00) begin
				cur_next.rxw_psc = cur_reg.rxw_psc - 8'h01;
			end else begin
				cur_next.rxw_psc = rxw_psc_reload; // R18
				if (cur_reg.rxw_cnt <= 20'h00001) begin
					cur_next.rxw_active = 1'b0;
					cur_next.rxw_cnt = 20'h00000;
				end else begin
					cur_next.rxw_cnt = cur_reg.rxw_cnt - 20'h00001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// clear everything, then set the fields that idle away from zero
			cur_reg <= '0;
			cur_reg.tmr_cfg <= TIMER_CFG_RESET;
			cur_reg.rxw_cfg <= RX_WAIT_CFG_RESET;
			cur_reg.preset <= TIMER_PRESET_RESET;
			cur_reg.tstate <= TMR_IDLE;
			cur_reg.awready <= 1'b1;
			cur_reg.wready <= 1'b1;
			cur_reg.arready <= 1'b1;
			cur_reg.bresp <= RESP_OKAY;
			cur_reg.rresp <= RESP_OKAY;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, each straight from a flop
	// ----------------------------------------------------------------
	assign s_axi_awready_out = cur_reg.awready;
	assign s_axi_wready_out = cur_reg.wready;
	assign s_axi_bresp_out = cur_reg.bresp;
	assign s_axi_bvalid_out = cur_reg.bvalid;
	assign s_axi_arready_out = cur_reg.arready;
	assign s_axi_rdata_out = cur_reg.rdata;
	assign s_axi_rresp_out = cur_reg.rresp;
	assign s_axi_rvalid_out = cur_reg.rvalid;
	assign timer_running_out = cur_reg.tstate[1]; // one-hot run bit
	assign timer_expired_out = cur_reg.expire_pulse;
	assign rx_guard_active_out = cur_reg.rxw_active;

endmodule : rf_event_timer_rx_wait

// ==== pkg/rf_timer_pkg.sv ====
// package for the rf event timer and receive wait guard block
// assumes a 50 MHz system clock and an axi4-lite master with 32-bit data
package rf_timer_pkg;

	// ----------------------------------------------------------------
	// clocking
	// ----------------------------------------------------------------
	localparam longint unsigned SYS_CLK_HZ = 64'd50000000;
	localparam longint unsigned CONTACTLESS_CLK_HZ = 64'd13560000;
	// phase step of the accumulator that paces contactless clock ticks
	localparam logic [31:0] UNIT_CLK_STEP = 32'((CONTACTLESS_CLK_HZ << 32) / SYS_CLK_HZ);

	// ----------------------------------------------------------------
	// register indices (printed offsets), byte address is four times this
	// ----------------------------------------------------------------
	localparam logic [7:0] TIMER_CFG_INDEX = 8'h10;
	localparam logic [7:0] RX_WAIT_CFG_INDEX = 8'h11;
	localparam logic [7:0] TIMER_PRESET_INDEX = 8'h20;
	localparam logic [7:0] TIMER_STATUS_INDEX = 8'h21;
	localparam logic [7:0] TIMER_COUNT_INDEX = 8'h22;

	// ----------------------------------------------------------------
	// second_timer_config fields
	// ----------------------------------------------------------------
	localparam int STOP_ON_RECEIVE_BEGIN_BIT = 20;
	localparam int STOP_ON_TRANSMIT_BEGIN_BIT = 19;
	localparam int STOP_ON_EXTERNAL_FIELD_SEEN_BIT = 18;
	localparam int STOP_ON_EXTERNAL_FIELD_LOST_BIT = 17;
	localparam int STOP_ON_OWN_FIELD_ON_BIT = 16;
	localparam int STOP_ON_OWN_FIELD_OFF_BIT = 15;
	localparam int START_ON_RECEIVE_BEGIN_BIT = 14;
	localparam int START_ON_RECEIVE_END_BIT = 13;
	localparam int START_ON_TRANSMIT_BEGIN_BIT = 12;
	localparam int START_ON_TRANSMIT_END_BIT = 11;
	localparam int START_ON_EXTERNAL_FIELD_SEEN_BIT = 10;
	localparam int START_ON_EXTERNAL_FIELD_LOST_BIT = 9;
	localparam int START_ON_OWN_FIELD_ON_BIT = 8;
	localparam int START_ON_OWN_FIELD_OFF_BIT = 7;
	localparam int START_IMMEDIATELY_BIT = 6;
	localparam int TICK_RATE_SELECT_LSB = 3;
	localparam int TICK_RATE_SELECT_MSB = 5;
	localparam int PRESCALER_USE_SELECT_BIT = 2;
	localparam int AUTO_RELOAD_ENABLE_BIT = 1;
	localparam logic [31:0] TIMER_CFG_WRITE_MASK = 32'h001ffffe;
	localparam logic [31:0] TIMER_CFG_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// receive_wait_guard_config fields
	// ----------------------------------------------------------------
	localparam int RX_WAIT_VALUE_LSB = 8;
	localparam int RX_WAIT_VALUE_MSB = 27;
	localparam int RX_WAIT_PRESCALER_LSB = 0;
	localparam int RX_WAIT_PRESCALER_MSB = 7;
	localparam logic [31:0] RX_WAIT_CFG_WRITE_MASK = 32'h0fffffff;
	localparam logic [31:0] RX_WAIT_CFG_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// own registers: preset and status
	// ----------------------------------------------------------------
	localparam logic [31:0] TIMER_PRESET_RESET = 32'h00000000;
	localparam int STATUS_RUNNING_BIT = 0;
	localparam int STATUS_EXPIRED_BIT = 1;
	localparam int STATUS_RX_GUARD_BIT = 2;

	// ----------------------------------------------------------------
	// axi responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : rf_timer_pkg

// ==== bench/rf_event_timer_rx_wait_asserts.sv ====
// port-level checks for the rf event timer and receive wait guard
// assumes a bind onto the top module, one clock, active-low async reset
`timescale 1ns/1ns
module rf_event_timer_rx_wait_asserts (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic transmit_end_in,
	input wire logic timer_running_out,
	input wire logic timer_expired_out,
	input wire logic rx_guard_active_out
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// all checks share one clock; reset hides the settling edges
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	a_expiry_one_cycle: assert property (timer_expired_out |=> !timer_expired_out)
		else $error("expiry flag held longer than one cycle");
	a_expiry_while_run: assert property ($rose(timer_expired_out) |-> $past(timer_running_out))
		else $error("expiry without a running timer");
	a_guard_from_tx: assert property ($rose(rx_guard_active_out) |-> $past(transmit_end_in))
		else $error("guard started without transmit end");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	a_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address open while answer pending");
	a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
	a_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
	a_write_reopen: assert property (s_axi_bvalid_out && s_axi_bready_in
		|=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out)
		else $error("write channels not reopened");

	c_launch: cover property ($rose(timer_running_out));
	c_reload: cover property (timer_expired_out && timer_running_out);
	c_guard_end: cover property ($fell(rx_guard_active_out));
endmodule : rf_event_timer_rx_wait_asserts

// ==== bench/tb_rf_event_timer_rx_wait.sv ====
// self-checking bench for the rf event timer and receive wait guard
// assumes the package and checker are compiled first; 50 MHz clock
`timescale 1ns/1ns
module tb_rf_event_timer_rx_wait;
	import rf_timer_pkg::*;
	localparam logic [7:0] A_CFG = TIMER_CFG_INDEX << 2;
	localparam logic [7:0] A_RXW = RX_WAIT_CFG_INDEX << 2;
	localparam logic [7:0] A_PRE = TIMER_PRESET_INDEX << 2;
	localparam logic [7:0] A_CNT = TIMER_COUNT_INDEX << 2;
	localparam logic [7:0] A_STA = TIMER_STATUS_INDEX << 2;
	logic ref_clk_in = 0, rst_b_in = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
	logic [7:0] aw_a = 0, ar_a = 0;
	logic [31:0] w_d = 0, r_d;
	logic rx_b = 0, rx_n = 0, rx_e = 0, tx_b = 0, tx_e = 0, ext_f = 0, own_f = 0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, running, expired, guard;
	logic [1:0] b_resp, r_resp;
	int fails = 0, checks = 0;

	always #10 ref_clk_in = ~ref_clk_in;

	rf_event_timer_rx_wait dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
		.s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
		.s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
		.s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_resp),
		.s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .receive_begin_in(rx_b),
		.receive_nibble_done_in(rx_n), .receive_end_in(rx_e), .transmit_begin_in(tx_b),
		.transmit_end_in(tx_e), .external_field_present_in(ext_f), .own_field_on_in(own_f),
		.timer_running_out(running), .timer_expired_out(expired), .rx_guard_active_out(guard));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// every wait is bounded; running out in wr, rd or wait_exp ends the run as a failure, other waits fail one check
	task automatic hang;
		fails++;
		$display("wrong value at %0t: wait ran out", $time);
		conclude();
	endtask : hang
	// both channels offered together, bready held until the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge ref_clk_in);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1;
		w_v <= 1;
		b_r <= 1;
		for (n = 0; n < 40 && !(b_v === 1'b1 && b_r); n++) begin
			@(posedge ref_clk_in);
			if (aw_v && aw_rdy) aw_v <= 0;
			if (w_v && w_rdy) w_v <= 0;
		end
		if (n == 40) hang();
		b_r <= 0;
		chk(32'(b_resp), 32'(er), "write response");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge ref_clk_in);
		ar_a <= a;
		ar_v <= 1;
		r_r <= 1;
		for (n = 0; n < 40 && !(r_v === 1'b1 && r_r); n++) begin
			@(posedge ref_clk_in);
			if (ar_v && ar_rdy) ar_v <= 0;
		end
		if (n == 40) hang();
		r_r <= 0;
		chk(r_d, exp, "read data");
		chk(32'(r_resp), 32'(er), "read response");
	endtask : rd
	// codes 0..3 pulses, 4..7 field levels, 8 first-nibble pulse
	task automatic fire(input int k);
		@(posedge ref_clk_in);
		case (k)
			0: rx_b <= 1;
			1: rx_e <= 1;
			2: tx_b <= 1;
			3: tx_e <= 1;
			4: ext_f <= 1;
			5: ext_f <= 0;
			6: own_f <= 1;
			7: own_f <= 0;
			default: rx_n <= 1;
		endcase
		@(posedge ref_clk_in);
		{rx_b, rx_e, tx_b, tx_e, rx_n} <= 5'h00;
	endtask : fire
	task automatic wait_run(input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim && running !== lvl; n++) @(posedge ref_clk_in);
		chk(32'(running), 32'(lvl), "timer running");
	endtask : wait_run
	task automatic wait_exp(input int lim);
		int n;
		for (n = 0; n < lim && expired !== 1'b1; n++) @(posedge ref_clk_in);
		if (n == lim) hang();
	endtask : wait_exp
	// expected length from contactless ticks; nco jitter allows a few cycles
	task automatic near(input int n, input real ticks, input string what);
		real e;
		e = ticks * 50.0 / 13.56;
		checks++;
		if (n < e - 4.0 || n > e + 4.0) begin
			fails++;
			$display("wrong value at %0t: %s took %0d cycles, about %0d expected", $time, what,
				n, int'(e));
		end
	endtask : near
	task automatic period(input real ticks);
		int n;
		wait_exp(2000);
		for (n = 1; n < 2000; n++) begin
			@(posedge ref_clk_in);
			if (expired === 1'b1) break;
		end
		near(n, ticks, "expiry period");
	endtask : period

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(A_CFG, TIMER_CFG_RESET, RESP_OKAY);
		rd(A_RXW, RX_WAIT_CFG_RESET, RESP_OKAY);
		wr(A_CFG, 32'hffffffbf, RESP_OKAY);
		rd(A_CFG, TIMER_CFG_WRITE_MASK & 32'hffffffbf, RESP_OKAY);
		wr(A_RXW, 32'hffffffff, RESP_OKAY);
		rd(A_RXW, RX_WAIT_CFG_WRITE_MASK, RESP_OKAY);
		wr(8'hfc, 32'h1, RESP_SLVERR);
		rd(8'hfc, 32'h0, RESP_SLVERR);
		wr(A_CFG, 32'h0, RESP_OKAY);
	endtask : t_regs
	task automatic t_start;
		int i;
		wr(A_PRE, 32'h4, RESP_OKAY);
		fire(2);
		@(posedge ref_clk_in);
		chk(32'(running), 0, "launch while disabled");
		for (i = 0; i < 8; i++) begin
			wr(A_CFG, 32'h1 << (14 - i), RESP_OKAY);
			fire(i);
			wait_run(1, 6);
			wait_exp(60);
			@(posedge ref_clk_in);
			chk(32'(running), 0, "running after expiry");
			rd(A_CNT, 32'h0, RESP_OKAY);
		end
		wr(A_CFG, 32'h1 << START_IMMEDIATELY_BIT, RESP_OKAY);
		wait_run(1, 4);
		wait_exp(60);
		rd(A_STA, 32'h6, RESP_OKAY);
		wr(A_STA, 32'h2, RESP_OKAY);
		rd(A_STA, 32'h4, RESP_OKAY);
	endtask : t_start
	task automatic t_stop;
		int i;
		int ev[6] = '{8, 2, 4, 5, 6, 7};
		wr(A_PRE, 32'hffff, RESP_OKAY);
		for (i = 0; i < 6; i++) begin
			wr(A_CFG, (32'h1 << (20 - i)) | 32'h40, RESP_OKAY);
			wait_run(1, 4);
			if (i == 0) fire(0);
			chk(32'(running), 1, "halted before the first nibble");
			fire(ev[i]);
			wait_run(0, 8);
		end
	endtask : t_stop
	task automatic t_rate;
		int s;
		wr(A_PRE, 32'd16, RESP_OKAY);
		wr(A_CFG, 32'h42, RESP_OKAY);
		period(16.0);
		wr(A_PRE, 32'd1, RESP_OKAY);
		for (s = 0; s < 8; s++) begin
			wr(A_CFG, 32'h46 | (32'(s) << TICK_RATE_SELECT_LSB), RESP_OKAY);
			period(real'(2 ** (s + 1)));
		end
		wr(A_CFG, (32'h1 << STOP_ON_OWN_FIELD_ON_BIT) | 32'h7e, RESP_OKAY);
		chk(32'(running), 1, "running before halt");
		fire(6);
		wait_run(0, 6);
	endtask : t_rate
	task automatic t_guard;
		int n;
		wr(A_RXW, 32'h0, RESP_OKAY);
		fire(3);
		@(posedge ref_clk_in);
		chk(32'(guard), 0, "guard with zero value");
		wr(A_RXW, (32'd2 << RX_WAIT_VALUE_LSB) | 32'h7f, RESP_OKAY);
		fire(3);
		@(posedge ref_clk_in);
		for (n = 0; n < 2000 && guard === 1'b1; n++) @(posedge ref_clk_in);
		near(n, 256.0, "guard length");
	endtask : t_guard

	// reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1;
		t_regs();
		t_start();
		t_stop();
		t_rate();
		t_guard();
		conclude();
	end
endmodule : tb_rf_event_timer_rx_wait

bind rf_event_timer_rx_wait rf_event_timer_rx_wait_asserts chk_i (.ref_clk_in, .rst_b_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.transmit_end_in, .timer_running_out, .timer_expired_out, .rx_guard_active_out);
